/* verilog/rsp_type_pkg.sv */
package rsp_type_pkg;

    // ************************************************************
    // command classes seen by the block
    // ************************************************************
    typedef enum logic [1:0] {
        CC_GET,
        CC_SET,
        CC_DISC,
        CC_NONE
    } cmd_class_t;

    // ************************************************************
    // field layout and fixed values
    // ************************************************************
    localparam int PID_W = 16;
    localparam int SUBDEV_W = 16;
    localparam int PDL_W = 8;
    localparam int CODE_W = 8;
    localparam int MSGCNT_W = 8;
    localparam int BLK_W = 8;
    localparam logic [PDL_W-1:0] PDL_TWO = 8'h02;
    localparam logic [PDL_W-1:0] PDL_NONE = 8'h00;
    localparam logic [MSGCNT_W-1:0] MSGCNT_RST = 8'h00;
    localparam logic [MSGCNT_W-1:0] MSGCNT_MAX = 8'hff;
    localparam logic [BLK_W-1:0] BLK_RST = 8'h00;
    localparam logic [PID_W-1:0] PID_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // estimate unit: one count is 100 ms
    localparam int EST_UNIT_MS = 100;
    localparam int CLK_MHZ = 20;
    localparam int EST_UNIT_CYC = EST_UNIT_MS * 1000 * CLK_MHZ;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        cmd_class_t cls;
        logic broadcast;
        logic [SUBDEV_W-1:0] subdev;
        logic [PID_W-1:0] pid;
    } cmd_t;

    typedef struct packed {
        cmd_class_t cls;
        logic [CODE_W-1:0] rtype;
        logic [MSGCNT_W-1:0] msg_count;
        logic [SUBDEV_W-1:0] subdev;
        logic [PID_W-1:0] pid;
        logic [PDL_W-1:0] pdl;
        logic [15:0] word;
        logic [BLK_W-1:0] block;
        logic from_queue;
    } rsp_t;

    typedef struct packed {
        cmd_class_t cls;
        logic [SUBDEV_W-1:0] subdev;
        logic [PID_W-1:0] pid;
    } qent_t;

endpackage

/* verilog/rsp_queue_mem.sv */
`timescale 1ns/1ns
module rsp_queue_mem
    import rsp_type_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire qent_t i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output qent_t o_rdata
);

    qent_t mem [DEPTH];

    // no reset: contents only matter once written
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule

/* verilog/responder_ack_type_control.sv */
`timescale 1ns/1ns
module responder_ack_type_control
    import rsp_type_pkg::*;
#(
    parameter logic [CODE_W-1:0] CODE_ACK = 8'h00,
    parameter logic [CODE_W-1:0] CODE_ACK_TIMER = 8'h01,
    parameter logic [CODE_W-1:0] CODE_NACK = 8'h02,
    parameter logic [CODE_W-1:0] CODE_ACK_OVF = 8'h03,
    parameter logic [PID_W-1:0] PID_QUEUED = 16'h0020,
    parameter int QDEPTH = 8,
    parameter int QAW = 3,
    parameter int EST_CYC = EST_UNIT_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_cmd_valid,
    input wire cmd_t i_cmd,
    input wire logic i_nack,
    input wire logic [15:0] i_nack_code,
    input wire logic i_defer,
    input wire logic [15:0] i_est_ticks,
    input wire logic i_ovf_more,
    input wire logic i_deferred_ready,
    input wire qent_t i_deferred,
    output logic o_rsp_valid,
    output rsp_t o_rsp,
    output logic [MSGCNT_W-1:0] o_msg_count,
    output logic o_queue_full,
    output logic o_est_tick
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ************************************************************
    // decode
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_QREAD, ST_QSEND} state_t;
    state_t state_r;
    state_t state_nxt;

    logic ovf_active_r;
    logic [PID_W-1:0] ovf_pid_r;
    logic [BLK_W-1:0] ovf_blk_r;
    logic [QAW:0] q_cnt_r;
    logic [QAW-1:0] q_wp_r;
    logic [QAW-1:0] q_rp_r;
    logic [MSGCNT_W-1:0] msg_cnt_r;
    logic [31:0] est_cnt_r;
    qent_t q_rdata;
    rsp_t rsp_r;
    rsp_t rsp_nxt;
    logic rsp_vld_r;
    logic q_full_r;
    logic tick_r;

    function automatic logic is_getset(input cmd_class_t c);
        return (c == CC_GET) || (c == CC_SET);
    endfunction

    wire logic answerable = i_cmd_valid && !i_cmd.broadcast
        && (is_getset(i_cmd.cls) || i_cmd.cls == CC_DISC);
    wire logic take = answerable && state_r == ST_IDLE;
    wire logic is_qget = i_cmd.cls == CC_GET && i_cmd.pid == PID_QUEUED;
    wire logic q_empty = q_cnt_r == '0;
    wire logic q_full = q_cnt_r == (QAW+1)'(QDEPTH);
    wire logic q_pop = take && is_qget && !q_empty;
    // read address holds until the entry is latched, so advance on send
    wire logic q_adv = state_r == ST_QSEND;
    wire logic q_push = i_deferred_ready && !q_full;
    // a different pid drops the overflow transfer
    wire logic ovf_abort = take && ovf_active_r && i_cmd.pid != ovf_pid_r;
    wire logic ovf_same = ovf_active_r && i_cmd.pid == ovf_pid_r;
    wire logic [BLK_W-1:0] blk_now = ovf_same ? ovf_blk_r : BLK_RST;
    wire logic ovf_go = take && i_cmd.cls == CC_GET && !is_qget
        && !i_nack && !i_defer && i_ovf_more;
    wire logic ovf_done = take && ovf_same && i_cmd.cls == CC_GET
        && !i_ovf_more;
    wire logic est_wrap = est_cnt_r == 32'(EST_CYC - 1);
    wire logic [MSGCNT_W-1:0] cnt_next =
        (q_push && msg_cnt_r != MSGCNT_MAX) ? msg_cnt_r + 1'b1 : msg_cnt_r;

    // ************************************************************
    // queued message store
    // ************************************************************
    // only deferred replies land here, never overflow blocks
    rsp_queue_mem #(.DEPTH(QDEPTH), .AW(QAW)) u_mem (
        .i_sys_clk(i_sys_clk),
        .i_we(q_push),
        .i_waddr(q_wp_r),
        .i_wdata(i_deferred),
        .i_raddr(q_rp_r),
        .o_rdata(q_rdata)
    );

    // ************************************************************
    // response select
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        rsp_nxt = rsp_r;
        unique case (state_r)
            ST_IDLE: begin
                if (q_pop) begin
                    state_nxt = ST_QREAD;
                end else if (take) begin
                    rsp_nxt.cls = i_cmd.cls;
                    rsp_nxt.msg_count = cnt_next;
                    rsp_nxt.subdev = i_cmd.subdev;
                    rsp_nxt.pid = i_cmd.pid;
                    rsp_nxt.pdl = PDL_NONE;
                    rsp_nxt.word = WORD_RST;
                    rsp_nxt.block = BLK_RST;
                    rsp_nxt.from_queue = 1'b0;
                    if (i_cmd.cls == CC_DISC) begin
                        rsp_nxt.rtype = CODE_ACK;
                    end else if (i_nack) begin
                        rsp_nxt.rtype = CODE_NACK;
                        rsp_nxt.pdl = PDL_TWO;
                        rsp_nxt.word = i_nack_code;
                    end else if (i_defer) begin
                        rsp_nxt.rtype = CODE_ACK_TIMER;
                        rsp_nxt.pdl = PDL_TWO;
                        rsp_nxt.word = i_est_ticks;
                    end else if (i_ovf_more && i_cmd.cls == CC_GET
                                 && !is_qget) begin
                        rsp_nxt.rtype = CODE_ACK_OVF;
                        rsp_nxt.block = blk_now;
                    end else begin
                        // plain ack, also last overflow block
                        rsp_nxt.rtype = CODE_ACK;
                        rsp_nxt.block = ovf_same ? ovf_blk_r : BLK_RST;
                    end
                end
            end
            ST_QREAD: state_nxt = ST_QSEND;
            ST_QSEND: begin
                // stored reply goes out as ack
                rsp_nxt.cls = q_rdata.cls;
                rsp_nxt.rtype = CODE_ACK;
                rsp_nxt.msg_count = cnt_next;
                rsp_nxt.subdev = q_rdata.subdev;
                rsp_nxt.pid = q_rdata.pid;
                rsp_nxt.pdl = PDL_NONE;
                rsp_nxt.word = WORD_RST;
                rsp_nxt.block = BLK_RST;
                rsp_nxt.from_queue = 1'b1;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
            rsp_r <= '0;
            rsp_vld_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rsp_r <= rsp_nxt;
            // each reply pulse has its type set
            rsp_vld_r <= (take && !q_pop) || state_r == ST_QSEND;
        end
    end

    // overflow block tracking; abort restarts at block zero
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ovf_active_r <= 1'b0;
            ovf_pid_r <= PID_RST;
            ovf_blk_r <= BLK_RST;
        end else if (ovf_go) begin
            ovf_active_r <= 1'b1;
            ovf_pid_r <= i_cmd.pid;
            ovf_blk_r <= blk_now + 1'b1;
        end else if (ovf_abort || ovf_done) begin
            ovf_active_r <= 1'b0;
            ovf_blk_r <= BLK_RST;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            q_wp_r <= '0;
            q_rp_r <= '0;
            q_cnt_r <= '0;
            q_full_r <= 1'b0;
        end else begin
            if (q_push) begin
                q_wp_r <= q_wp_r + 1'b1;
            end
            if (q_adv) begin
                q_rp_r <= q_rp_r + 1'b1;
            end
            q_cnt_r <= q_cnt_r + (QAW+1)'(q_push) - (QAW+1)'(q_adv);
            q_full_r <= q_cnt_r + (QAW+1)'(q_push) - (QAW+1)'(q_adv)
                == (QAW+1)'(QDEPTH);
        end
    end

    // count rises on queue entry, saturates
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            msg_cnt_r <= MSGCNT_RST;
        end else begin
            msg_cnt_r <= cnt_next;
        end
    end

    // 100 ms tick helps callers count down estimates
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            est_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            est_cnt_r <= est_wrap ? '0 : est_cnt_r + 1'b1;
            tick_r <= est_wrap;
        end
    end

    assign o_rsp_valid = rsp_vld_r;
    assign o_rsp = rsp_r;
    assign o_msg_count = msg_cnt_r;
    assign o_queue_full = q_full_r;
    assign o_est_tick = tick_r;

    // ************************************************************
    // checks
    // ************************************************************
    // discovery reply is ack
    disc_ack_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        o_rsp_valid && o_rsp.cls == CC_DISC |-> o_rsp.rtype == CODE_ACK)
        else $error("discovery reply not ack");
    bcast_quiet_a: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_r)
        i_cmd_valid && i_cmd.broadcast && state_r == ST_IDLE
        |=> !o_rsp_valid)
        else $error("broadcast answered");
    timer_len_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        o_rsp_valid && o_rsp.rtype == CODE_ACK_TIMER && !o_rsp.from_queue
        |-> o_rsp.pdl == PDL_TWO)
        else $error("timer length wrong");
    nack_fmt_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        take && !q_pop && is_getset(i_cmd.cls) && i_nack
        |=> o_rsp_valid && o_rsp.word == $past(i_nack_code)
            && o_rsp.pid == $past(i_cmd.pid) && o_rsp.pdl == PDL_TWO)
        else $error("nack format wrong");
    cnt_push_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        q_push && msg_cnt_r != MSGCNT_MAX |=> msg_cnt_r == $past(msg_cnt_r) + 1)
        else $error("message count not incremented");
    ovf_abort_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        ovf_abort && !ovf_go |=> !ovf_active_r && ovf_blk_r == BLK_RST)
        else $error("overflow not aborted");
    ovf_step_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        ovf_go && ovf_same |=> ovf_blk_r == $past(ovf_blk_r) + 1)
        else $error("overflow block not advanced");
    // queued get answered three cycles after the pop
    qget_ans_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n_r)
        q_pop |=> !o_rsp_valid ##2 o_rsp_valid && o_rsp.from_queue)
        else $error("queued reply missing");

endmodule

/* verification/rdm_ctrl_model.sv */
`timescale 1ns/1ns
module rdm_ctrl_model
    import rsp_type_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rsp_valid,
    output logic o_cmd_valid,
    output cmd_t o_cmd
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
    end

    // issues any command and counts cycles to the reply
    // one command per call; the caller picks class and pid
    task automatic issue(input cmd_t c, output int lat);
        lat = 0;
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b1;
        o_cmd = c;
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b0;
        // released lines show the inverse, never a stale copy
        o_cmd = ~c;
        for (int i = 1; i <= 5 && lat == 0; i++) begin
            if (i_rsp_valid === 1'b1) begin
                lat = i;
            end else begin
                @(negedge i_sys_clk);
            end
        end
    endtask
endmodule

/* verification/responder_ack_type_control_tb.sv */
`timescale 1ns/1ns
module responder_ack_type_control_tb;
    import rsp_type_pkg::*;
    // non-default codes so a hard-wired encoding shows up
    localparam logic [CODE_W-1:0] C_ACK = 8'h11;
    localparam logic [CODE_W-1:0] C_TMR = 8'h22;
    localparam logic [CODE_W-1:0] C_NAK = 8'h33;
    localparam logic [CODE_W-1:0] C_OVF = 8'h44;
    localparam logic [PID_W-1:0] P_Q = 16'h0020;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid, rsp_valid, queue_full, est_tick;
    cmd_t cmd;
    rsp_t rsp;
    logic nack = 1'b0, defer = 1'b0, ovf = 1'b0, dready = 1'b0, bcast = 1'b0;
    logic [15:0] ncode = 16'h0000, est = 16'h0000;
    qent_t dent = '0;
    logic [MSGCNT_W-1:0] msg_count;
    int n_mismatch = 0;
    int checks_done = 0;
    int mcnt = 0;

    always #25 sys_clk = ~sys_clk;

    responder_ack_type_control #(.CODE_ACK(C_ACK), .CODE_ACK_TIMER(C_TMR),
        .CODE_NACK(C_NAK), .CODE_ACK_OVF(C_OVF), .PID_QUEUED(P_Q),
        .EST_CYC(10)) responder_ack_type_control_inst (
        .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_nack(nack), .i_nack_code(ncode), .i_defer(defer),
        .i_est_ticks(est), .i_ovf_more(ovf), .i_deferred_ready(dready),
        .i_deferred(dent), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
        .o_msg_count(msg_count), .o_queue_full(queue_full),
        .o_est_tick(est_tick));

    rdm_ctrl_model rdm_ctrl_model_inst (.i_sys_clk(sys_clk),
        .i_rsp_valid(rsp_valid), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic summarize();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic do_cmd(input cmd_class_t c, input logic [15:0] pid,
        input int le, input logic [7:0] rt, input logic [7:0] pdl,
        input logic [15:0] wd);
        cmd_t cm;
        int lat;
        cm = '{cls: c, broadcast: bcast, subdev: pid ^ 16'h0f0f, pid: pid};
        rdm_ctrl_model_inst.issue(cm, lat);
        chk("latency", 16'(le), 16'(lat));
        if (le == 1) begin
            chk("cls", {14'h0000, c}, {14'h0000, rsp.cls});
            chk("rtype", {8'h00, rt}, {8'h00, rsp.rtype});
            chk("pdl", {8'h00, pdl}, {8'h00, rsp.pdl});
            chk("subdev", cm.subdev, rsp.subdev);
            chk("pid", pid, rsp.pid);
            chk("count", 16'(mcnt), {8'h00, rsp.msg_count});
            chk("from_queue", 16'h0000, {15'h0000, rsp.from_queue});
            chk("word", wd, rsp.word);
        end
    endtask

    task automatic push(input logic [15:0] pid);
        @(negedge sys_clk);
        dready = 1'b1;
        dent = '{cls: CC_SET, subdev: 16'h0007, pid: pid};
        @(negedge sys_clk);
        dready = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_types();
        nack = 1'b1;
        defer = 1'b1;
        do_cmd(CC_DISC, 16'h0001, 1, C_ACK, PDL_NONE, 16'h0000);
        nack = 1'b0;
        defer = 1'b0;
        do_cmd(CC_GET, 16'h0060, 1, C_ACK, PDL_NONE, 16'h0000);
        do_cmd(CC_SET, 16'h1001, 1, C_ACK, PDL_NONE, 16'h0000);
    endtask

    task automatic t_nack();
        nack = 1'b1;
        defer = 1'b1;
        ncode = 16'h0a05;
        do_cmd(CC_GET, 16'h0200, 1, C_NAK, PDL_TWO, 16'h0a05);
        do_cmd(CC_SET, 16'h8123, 1, C_NAK, PDL_TWO, 16'h0a05);
        nack = 1'b0;
        est = 16'h0258;
        do_cmd(CC_GET, 16'h0405, 1, C_TMR, PDL_TWO, 16'h0258);
        est = 16'hffff;
        do_cmd(CC_SET, 16'h0406, 1, C_TMR, PDL_TWO, 16'hffff);
        defer = 1'b0;
    endtask

    task automatic t_ovf();
        ovf = 1'b1;
        for (int b = 0; b < 3; b++) begin
            do_cmd(CC_GET, 16'h0010, 1, C_OVF, PDL_NONE, 16'h0000);
            chk("block", 16'(b), {8'h00, rsp.block});
        end
        chk("count", 16'(mcnt), {8'h00, msg_count});
        ovf = 1'b0;
        do_cmd(CC_GET, 16'h0050, 1, C_ACK, PDL_NONE, 16'h0000);
        ovf = 1'b1;
        do_cmd(CC_GET, 16'h0010, 1, C_OVF, PDL_NONE, 16'h0000);
        chk("block", 16'h0000, {8'h00, rsp.block});
        do_cmd(CC_SET, 16'h0010, 1, C_ACK, PDL_NONE, 16'h0000);
        do_cmd(CC_GET, 16'h0010, 1, C_OVF, PDL_NONE, 16'h0000);
        ovf = 1'b0;
        do_cmd(CC_GET, 16'h0010, 1, C_ACK, PDL_NONE, 16'h0000);
        chk("block", 16'h0002, {8'h00, rsp.block});
    endtask

    task automatic t_queue();
        cmd_t cm;
        int lat;
        do_cmd(CC_GET, P_Q, 1, C_ACK, PDL_NONE, 16'h0000);
        push(16'h0405);
        mcnt++;
        chk("msg_count", 16'(mcnt), {8'h00, msg_count});
        cm = '{cls: CC_GET, broadcast: 1'b0, subdev: 16'h0000, pid: P_Q};
        rdm_ctrl_model_inst.issue(cm, lat);
        chk("latency", 16'd3, 16'(lat));
        chk("queued pid", 16'h0405, rsp.pid);
        chk("queued subdev", 16'h0007, rsp.subdev);
        chk("queued cls", {14'h0000, CC_SET}, {14'h0000, rsp.cls});
        chk("from_queue", 16'h0001, {15'h0000, rsp.from_queue});
        chk("count", 16'(mcnt), {8'h00, rsp.msg_count});
        repeat (3) @(negedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            push(16'h0100 + 16'(k));
            mcnt++;
            chk("msg_count", 16'(mcnt), {8'h00, msg_count});
        end
        @(negedge sys_clk);
        chk("queue_full", 16'h0001, {15'h0000, queue_full});
        push(16'h0200);
        chk("msg_count", 16'(mcnt), {8'h00, msg_count});
    endtask

    task automatic t_silent();
        bcast = 1'b1;
        do_cmd(CC_GET, 16'h0060, 0, C_ACK, PDL_NONE, 16'h0000);
        do_cmd(CC_SET, 16'h0061, 0, C_ACK, PDL_NONE, 16'h0000);
        bcast = 1'b0;
        do_cmd(CC_NONE, 16'h0060, 0, C_ACK, PDL_NONE, 16'h0000);
        do_cmd(CC_SET, 16'h0061, 1, C_ACK, PDL_NONE, 16'h0000);
    endtask

    task automatic t_tick();
        int n;
        n = 0;
        while (est_tick !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        @(negedge sys_clk);
        while (est_tick !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chk("tick spacing", 16'd9, 16'(n));
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("rsp_valid", 16'h0000, {15'h0000, rsp_valid});
        chk("msg_count", 16'h0000, {8'h00, msg_count});
        t_types();
        t_nack();
        t_ovf();
        t_silent();
        t_tick();
        t_queue();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end
endmodule
